// >>> hw/dic_top.sv
// Digital input conditioning: inversion, forcing, routing, special
// functions, threshold/differential selects and home capture.
// Assumes pins synchronous to sys_clk and a one-cycle register port.
`timescale 1ns/1ps
module dic_top #(
   parameter int N_IN = 32
) (
   input  wire logic                 sys_clk,
   input  wire logic                 srst,
   input  wire dic_pkg::dic_bus_req_t bus,
   output logic [31:0]               rdata,
   input  wire logic [N_IN-1:0]      pin_in,
   input  wire logic                 clk_dir_mode,
   input  wire dic_pkg::dic_pos_t    pos,
   output logic [N_IN-1:0]           input_result_word,
   output logic [N_IN-1:0]           thresh_24v,
   output logic                      diff_mode,
   output logic                      neg_limit,
   output logic                      pos_limit,
   output logic                      home_switch,
   output logic                      interlock,
   output logic                      irq
);
   // Elaboration check: register words hold at most 32 inputs
   if (N_IN < 4 || N_IN > 32) begin : g_bad_width
      $error("N_IN must be between 4 and 32");
   end

   logic [31:0] special_reg;
   logic [31:0] invert_reg;
   logic [31:0] force_en_reg;
   logic [31:0] force_val_reg;
   logic [31:0] raw_reg;
   logic [31:0] thresh_reg;
   logic [31:0] diff_reg;
   logic [31:0] route_en_reg;
   logic [31:0] cap_ctrl_reg;
   logic [7:0]  route_sel_reg [32];
   localparam int IRQ_BITS_W = dic_pkg::IRQ_BITS;
   logic [IRQ_BITS_W-1:0] irq_stat_reg;
   logic [IRQ_BITS_W-1:0] irq_en_reg;

   logic [31:0] cond_word;
   logic [31:0] routed_word;
   logic [31:0] result_next;
   logic [31:0] cap_count;
   logic [31:0] cap_user;
   logic [31:0] cap_enc;
   logic        capture;
   logic        cap_restart;
   logic        sel_hit;
   logic [4:0]  sel_idx;
   logic [IRQ_BITS_W-1:0] irq_event;

   // Decode of the routing selector window
   assign sel_hit = (bus.addr[7] == 1'b1);
   assign sel_idx = bus.addr[6:2];

   assign cap_restart = bus.wr && bus.addr == dic_pkg::OFF_CAP_CTRL
                        && bus.wdata[1:0] != 2'h0
                        && bus.wdata[31:2] == 30'h0;

   // Software-held configuration words
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         special_reg   <= dic_pkg::RST_WORD;
         invert_reg    <= dic_pkg::RST_WORD;
         force_en_reg  <= dic_pkg::RST_WORD;
         force_val_reg <= dic_pkg::RST_WORD;
         thresh_reg    <= dic_pkg::RST_WORD;
         diff_reg      <= dic_pkg::RST_WORD;
         route_en_reg  <= dic_pkg::RST_WORD;
         cap_ctrl_reg  <= dic_pkg::RST_WORD;
      end else if (bus.wr) begin
         case (bus.addr)
            dic_pkg::OFF_SPECIAL_EN: special_reg   <= bus.wdata;
            dic_pkg::OFF_INVERT:     invert_reg    <= bus.wdata;
            dic_pkg::OFF_FORCE_EN:   force_en_reg  <= bus.wdata;
            dic_pkg::OFF_FORCE_VAL:  force_val_reg <= bus.wdata;
            dic_pkg::OFF_THRESH:     thresh_reg    <= bus.wdata;
            dic_pkg::OFF_DIFF:       diff_reg      <= bus.wdata;
            dic_pkg::OFF_ROUTE_EN:   route_en_reg  <= bus.wdata;
            dic_pkg::OFF_CAP_CTRL:   cap_ctrl_reg  <= bus.wdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         for (int i = 0; i < 32; i++) begin
            route_sel_reg[i] <= dic_pkg::RST_SEL;
         end
      end else if (bus.wr && sel_hit) begin
         route_sel_reg[sel_idx] <= bus.wdata[7:0];
      end
   end

   // raw levels track the pins every cycle
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         raw_reg <= dic_pkg::RST_WORD;
      end else begin
         raw_reg <= 32'(pin_in);
      end
   end

   // Per-bit conditioning and routing
   for (genvar b = 0; b < 32; b++) begin : g_bit
      logic inv_ok;
      logic inv_lvl;
      assign inv_ok = invert_reg[b]
                      && !(clk_dir_mode && b < 2);
      assign inv_lvl = raw_reg[b] ^ inv_ok;
      assign cond_word[b] = force_en_reg[b] ? force_val_reg[b] : inv_lvl;
      // source 0 is off, 1..32 pick a conditioned input
      assign routed_word[b] =
         (route_sel_reg[b] != 8'h00 && route_sel_reg[b] <= 8'h20)
         ? cond_word[5'(route_sel_reg[b] - 8'h01)] : 1'b0;
   end

   assign result_next = route_en_reg[0] ? routed_word : cond_word;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         input_result_word <= '0;
      end else begin
         input_result_word <= result_next[N_IN-1:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         thresh_24v <= '0;
         diff_mode  <= 1'b0;
      end else begin
         thresh_24v <= thresh_reg[N_IN-1:0];
         diff_mode  <= diff_reg[0];
      end
   end

   // only low enable bits gate functions
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         neg_limit   <= 1'b0;
         pos_limit   <= 1'b0;
         home_switch <= 1'b0;
         interlock   <= 1'b0;
      end else begin
         neg_limit   <= special_reg[dic_pkg::BIT_NEG_LIMIT]
                        & result_next[dic_pkg::BIT_NEG_LIMIT];
         pos_limit   <= special_reg[dic_pkg::BIT_POS_LIMIT]
                        & result_next[dic_pkg::BIT_POS_LIMIT];
         home_switch <= special_reg[dic_pkg::BIT_HOME]
                        & result_next[dic_pkg::BIT_HOME];
         interlock   <= special_reg[dic_pkg::BIT_INTERLOCK]
                        & result_next[dic_pkg::BIT_INTERLOCK];
      end
   end

   // Capture runs from the home switch only while its function is on
   dic_capture u_capture (
      .sys_clk    (sys_clk),
      .srst       (srst),
      .home_level (home_switch),
      .mode       (cap_ctrl_reg[1:0]),
      .restart    (cap_restart),
      .pos        (pos),
      .cnt_wr     (bus.wr && bus.addr == dic_pkg::OFF_CAP_EVENTS),
      .user_wr    (bus.wr && bus.addr == dic_pkg::OFF_CAP_USER),
      .enc_wr     (bus.wr && bus.addr == dic_pkg::OFF_CAP_ENC),
      .wdata      (bus.wdata),
      .capture    (capture),
      .count_reg  (cap_count),
      .user_reg   (cap_user),
      .enc_reg    (cap_enc)
   );

   // Interrupt events: capture, limit reached, interlock open
   assign irq_event[dic_pkg::IRQ_CAPTURE]   = capture;
   assign irq_event[dic_pkg::IRQ_LIMIT]     = (neg_limit | pos_limit);
   assign irq_event[dic_pkg::IRQ_INTERLOCK] = interlock;

   // Sticky status; a new event wins over a clear in the same cycle
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         irq_stat_reg <= '0;
      end else begin
         irq_stat_reg <= (irq_stat_reg
            & ~((bus.wr && bus.addr == dic_pkg::OFF_IRQ_CLEAR)
                ? bus.wdata[IRQ_BITS_W-1:0] : '0))
            | irq_event;
      end
   end

   // Interrupt enable and level output
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         irq_en_reg <= '0;
      end else if (bus.wr && bus.addr == dic_pkg::OFF_IRQ_ENABLE) begin
         irq_en_reg <= bus.wdata[IRQ_BITS_W-1:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_reg & irq_en_reg);
      end
   end

   // Read data one cycle after the strobe, zero otherwise
   always_ff @(posedge sys_clk) begin
      if (srst || !bus.rd) begin
         rdata <= dic_pkg::RST_WORD;
      end else if (sel_hit) begin
         rdata <= {24'h0, route_sel_reg[sel_idx]};
      end else begin
         case (bus.addr)
            dic_pkg::OFF_CTRL_COUNT:  rdata <= {24'h0,
                                               dic_pkg::RST_CTRL_COUNT};
            dic_pkg::OFF_SPECIAL_EN:  rdata <= special_reg;
            dic_pkg::OFF_INVERT:      rdata <= invert_reg;
            dic_pkg::OFF_FORCE_EN:    rdata <= force_en_reg;
            dic_pkg::OFF_FORCE_VAL:   rdata <= force_val_reg;
            dic_pkg::OFF_RAW:         rdata <= raw_reg;
            dic_pkg::OFF_THRESH:      rdata <= thresh_reg;
            dic_pkg::OFF_DIFF:        rdata <= diff_reg;
            dic_pkg::OFF_ROUTE_EN:    rdata <= route_en_reg;
            dic_pkg::OFF_ROUTE_COUNT: rdata <= {24'h0,
                                               dic_pkg::RST_ROUTE_COUNT};
            dic_pkg::OFF_CAP_COUNT_N: rdata <= {24'h0,
                                               dic_pkg::RST_CAP_COUNT_N};
            dic_pkg::OFF_CAP_CTRL:    rdata <= cap_ctrl_reg;
            dic_pkg::OFF_CAP_EVENTS:  rdata <= cap_count;
            dic_pkg::OFF_CAP_USER:    rdata <= cap_user;
            dic_pkg::OFF_CAP_ENC:     rdata <= cap_enc;
            dic_pkg::OFF_RESULT:      rdata <= 32'(input_result_word);
            dic_pkg::OFF_IRQ_STATUS:  rdata <= 32'(irq_stat_reg);
            dic_pkg::OFF_IRQ_ENABLE:  rdata <= 32'(irq_en_reg);
            default:                  rdata <= dic_pkg::RST_WORD;
         endcase
      end
   end

   // Assertions
   // disabled limit low
   AST_SPECIAL_OFF: assert property (
      @(posedge sys_clk) disable iff (srst)
      !special_reg[dic_pkg::BIT_NEG_LIMIT] |=> !neg_limit)
      else $error("negative limit active while disabled");
   AST_HOME_MAP: assert property (
      @(posedge sys_clk) disable iff (srst)
      special_reg[dic_pkg::BIT_HOME]
      |=> home_switch == $past(result_next[dic_pkg::BIT_HOME]))
      else $error("home switch not taken from bit 2");
   AST_FORCE: assert property (
      @(posedge sys_clk) disable iff (srst)
      (force_en_reg[0] && !route_en_reg[0])
      |=> input_result_word[0] == $past(force_val_reg[0]))
      else $error("forced value not shown");
   AST_INVERT: assert property (
      @(posedge sys_clk) disable iff (srst)
      (!force_en_reg[5] && !route_en_reg[0])
      |=> input_result_word[5] == $past(raw_reg[5] ^ invert_reg[5]))
      else $error("inversion wrong on input 6");
   AST_RAW: assert property (
      @(posedge sys_clk) disable iff (srst)
      1'b1 |=> raw_reg == $past(32'(pin_in)))
      else $error("raw word does not follow pins");
   AST_THRESH: assert property (
      @(posedge sys_clk) disable iff (srst)
      1'b1 |=> thresh_24v == $past(thresh_reg[N_IN-1:0]))
      else $error("threshold select not driven");
   AST_ROUTE_OFF: assert property (
      @(posedge sys_clk) disable iff (srst)
      !route_en_reg[0]
      |=> input_result_word == $past(cond_word[N_IN-1:0]))
      else $error("result differs from conditioned word");
   AST_CAP_CLEAR: assert property (
      @(posedge sys_clk) disable iff (srst)
      cap_restart |=> cap_count == 32'h0)
      else $error("capture count not cleared");
   AST_CAP_COUNT: assert property (
      @(posedge sys_clk) disable iff (srst)
      (capture && !cap_restart)
      |=> cap_count == $past(cap_count) + 32'h0000_0001)
      else $error("capture count not advanced");
   AST_CAP_LATCH: assert property (
      @(posedge sys_clk) disable iff (srst)
      capture |=> cap_enc == $past(pos.enc_pos)
                  && cap_user == $past(pos.user_pos))
      else $error("capture did not latch position");
   AST_CAP_OFF: assert property (
      @(posedge sys_clk) disable iff (srst)
      cap_ctrl_reg[1:0] == 2'h0 |-> !capture)
      else $error("capture while disabled");
   AST_CAP_RISE: assert property (
      @(posedge sys_clk) disable iff (srst)
      (cap_ctrl_reg[1:0] == 2'h1 && $rose(home_switch)) |-> capture)
      else $error("rising home edge not captured");
   AST_DIFF: assert property (
      @(posedge sys_clk) disable iff (srst)
      $changed(diff_reg[0]) |=> diff_mode == $past(diff_reg[0]))
      else $error("differential mode not switched");
endmodule

// >>> hw/dic_pkg.sv
// Package for the digital input conditioning block: register offsets,
// reset values, capture modes and the bus carrier struct.
// Assumes a single 100 MHz clock and a word-wide register port.
package dic_pkg;

   // Register byte offsets (one aligned word each)
   localparam logic [7:0] OFF_CTRL_COUNT   = 8'h00;
   localparam logic [7:0] OFF_SPECIAL_EN   = 8'h04;
   localparam logic [7:0] OFF_INVERT       = 8'h08;
   localparam logic [7:0] OFF_FORCE_EN     = 8'h0C;
   localparam logic [7:0] OFF_FORCE_VAL    = 8'h10;
   localparam logic [7:0] OFF_RAW          = 8'h14;
   localparam logic [7:0] OFF_THRESH       = 8'h18;
   localparam logic [7:0] OFF_DIFF         = 8'h1C;
   localparam logic [7:0] OFF_ROUTE_EN     = 8'h20;
   localparam logic [7:0] OFF_ROUTE_COUNT  = 8'h24;
   localparam logic [7:0] OFF_CAP_COUNT_N  = 8'h28;
   localparam logic [7:0] OFF_CAP_CTRL     = 8'h2C;
   localparam logic [7:0] OFF_CAP_EVENTS   = 8'h30;
   localparam logic [7:0] OFF_CAP_USER     = 8'h34;
   localparam logic [7:0] OFF_CAP_ENC      = 8'h38;
   localparam logic [7:0] OFF_RESULT       = 8'h3C;
   localparam logic [7:0] OFF_IRQ_STATUS   = 8'h40;
   localparam logic [7:0] OFF_IRQ_CLEAR    = 8'h44;
   localparam logic [7:0] OFF_IRQ_ENABLE   = 8'h48;
   // Routing selectors: 32 words from this base
   localparam logic [7:0] OFF_ROUTE_SEL    = 8'h80;

   // Read-only entry counts, then reset values
   localparam logic [7:0] RST_CTRL_COUNT   = 8'h08;
   localparam logic [7:0] RST_ROUTE_COUNT  = 8'h20;
   localparam logic [7:0] RST_CAP_COUNT_N  = 8'h04;
   localparam logic [31:0] RST_WORD        = 32'h0000_0000;
   localparam logic [7:0] RST_SEL          = 8'h00;

   // Special-function bit positions
   localparam int BIT_NEG_LIMIT = 0;
   localparam int BIT_POS_LIMIT = 1;
   localparam int BIT_HOME      = 2;
   localparam int BIT_INTERLOCK = 3;
   localparam int SPECIAL_BITS  = 16;

   // Interrupt status bit positions
   localparam int IRQ_CAPTURE   = 0;
   localparam int IRQ_LIMIT     = 1;
   localparam int IRQ_INTERLOCK = 2;
   localparam int IRQ_BITS      = 3;

   // Capture trigger modes
   typedef enum logic [1:0] {
      DIC_CAP_OFF, DIC_CAP_RISE, DIC_CAP_FALL, DIC_CAP_BOTH
   } dic_cap_mode_t;

   // Register bus request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } dic_bus_req_t;

   // Position inputs sampled at a capture
   typedef struct packed {
      logic [31:0] user_pos;
      logic [31:0] enc_pos;
   } dic_pos_t;

endpackage

// >>> hw/dic_capture.sv
// Home-switch capture unit: edge detect, position latch, event counter.
// Assumes the home level is already conditioned and synchronous.
`timescale 1ns/1ps
module dic_capture (
   input  wire logic               sys_clk,
   input  wire logic               srst,
   input  wire logic               home_level,
   input  wire logic [1:0]         mode,
   input  wire logic               restart,
   input  wire dic_pkg::dic_pos_t  pos,
   input  wire logic               cnt_wr,
   input  wire logic               user_wr,
   input  wire logic               enc_wr,
   input  wire logic [31:0]        wdata,
   output logic                    capture,
   output logic [31:0]             count_reg,
   output logic [31:0]             user_reg,
   output logic [31:0]             enc_reg
);
   logic home_prev_reg;
   logic rise;
   logic fall;

   // Previous home level for edge detection
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         home_prev_reg <= 1'b0;
      end else begin
         home_prev_reg <= home_level;
      end
   end

   assign rise = home_level & ~home_prev_reg;
   assign fall = ~home_level & home_prev_reg;

   always_comb begin
      case (dic_pkg::dic_cap_mode_t'(mode))
         dic_pkg::DIC_CAP_RISE: capture = rise;
         dic_pkg::DIC_CAP_FALL: capture = fall;
         dic_pkg::DIC_CAP_BOTH: capture = rise | fall;
         default:               capture = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (srst || restart) begin
         count_reg <= dic_pkg::RST_WORD;
      end else if (capture) begin
         count_reg <= count_reg + 32'h0000_0001;
      end else if (cnt_wr) begin
         count_reg <= wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         user_reg <= dic_pkg::RST_WORD;
         enc_reg  <= dic_pkg::RST_WORD;
      end else if (capture) begin
         user_reg <= pos.user_pos;
         enc_reg  <= pos.enc_pos;
      end else begin
         if (user_wr) user_reg <= wdata;
         if (enc_wr)  enc_reg  <= wdata;
      end
   end
endmodule

// >>> verif/dic_switch_model.sv
// Far-side model: switch levels on the input pins and the encoder position.
// Assumes the bench commands levels just after a rising edge of sys_clk.
`timescale 1ns/1ps
module dic_switch_model (
   input  wire logic              sys_clk,
   input  wire logic              slow,
   input  wire logic [31:0]       lvl_cmd,
   input  wire dic_pkg::dic_pos_t pos_cmd,
   output logic [31:0]            pin_in,
   output dic_pkg::dic_pos_t      pos
);
   logic [31:0] lvl_dly;

   // A slow switch settles one cycle late; the position follows its command
   always_ff @(posedge sys_clk) begin
      lvl_dly <= lvl_cmd;
      pin_in  <= slow ? lvl_dly : lvl_cmd;
      pos     <= pos_cmd;
   end
endmodule

// >>> verif/digital_input_conditioning_tb_top.sv
// Self-checking bench for the input conditioning block.
// Assumes dic_top with a one-cycle register port and the switch model.
`timescale 1ns/1ps
module digital_input_conditioning_tb_top;
   typedef struct {int sel; logic [31:0] val;} dic_note_t;
   logic                  sys_clk = 1'b0;
   logic                  srst = 1'b1;
   dic_pkg::dic_bus_req_t bus = '0;
   logic                  clk_dir_mode = 1'b0;
   logic                  slow = 1'b0;
   logic [31:0]           lvl = 32'h0;
   dic_pkg::dic_pos_t     pos_cmd = '0;
   dic_pkg::dic_pos_t     pos;
   logic [31:0]           pin_in, rdata, res, th;
   logic                  diff_mode, irq, nl, pl, hs, il;
   int                    errors = 0;
   int                    n_compared = 0;
   dic_note_t             q[$];
   string                 nm[6] = '{"rdata", "result", "thresh", "diff",
                                    "special", "irq"};

   always #5 sys_clk = ~sys_clk;

   dic_switch_model PARTNER (.sys_clk(sys_clk), .slow(slow), .lvl_cmd(lvl),
      .pos_cmd(pos_cmd), .pin_in(pin_in), .pos(pos));

   dic_top #(.N_IN(32)) DUT (.sys_clk(sys_clk), .srst(srst), .bus(bus),
      .rdata(rdata), .pin_in(pin_in), .clk_dir_mode(clk_dir_mode),
      .pos(pos), .input_result_word(res), .thresh_24v(th),
      .diff_mode(diff_mode), .neg_limit(nl), .pos_limit(pl),
      .home_switch(hs), .interlock(il), .irq(irq));

   // Oldest note is compared at the falling edge, where outputs are settled
   always @(negedge sys_clk) begin
      dic_note_t   n;
      logic [31:0] seen;
      if (q.size() > 0) begin
         n = q.pop_front();
         case (n.sel)
            0: seen = rdata;
            1: seen = res;
            2: seen = th;
            3: seen = {31'h0, diff_mode};
            4: seen = {28'h0, il, hs, pl, nl};
            default: seen = {31'h0, irq};
         endcase
         n_compared++;
         if (seen !== n.val) begin
            errors++;
            $display("FAIL %s expected %h seen %h", nm[n.sel], n.val, seen);
         end
      end
   end

   // One bus cycle; the strobe is only dropped by idle, never twice a step
   task automatic op(logic w, logic r, logic [7:0] a, logic [31:0] d);
      bus <= '{wr: w, rd: r, addr: a, wdata: d};
      @(posedge sys_clk);
   endtask

   task automatic idle(int n);
      bus <= '0;
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic wr(logic [7:0] a, logic [31:0] d);
      op(1'b1, 1'b0, a, d);
   endtask

   // Read data stand in the cycle after the strobe, one note per cycle
   task automatic rd(logic [7:0] a, logic [31:0] e);
      op(1'b0, 1'b1, a, 32'h0);
      q.push_back('{0, e});
   endtask

   // Six idle cycles cover the pin-to-irq pipeline and a slow switch
   task automatic lv(int sel, logic [31:0] e);
      idle(6);
      q.push_back('{sel, e});
   endtask

   // Inversion first, then forcing; clock/direction inputs stay uninverted
   function automatic logic [31:0] cond(logic [31:0] r, m, fe, fv,
                                        logic cdm);
      logic [31:0] inv;
      inv = m;
      if (cdm)
         inv[1:0] = 2'h0;
      return ((r ^ inv) & ~fe) | (fv & fe);
   endfunction

   task automatic end_of_test();
      if (errors == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // A hang counts as a mismatch and ends the run the usual way
   initial begin
      repeat (20000) @(posedge sys_clk);
      errors++;
      end_of_test();
   end

   initial begin
      logic [31:0]       r, m, fe, fv, e, c;
      logic [7:0]        s;
      int                md;
      dic_pkg::dic_pos_t p1, p2, last;
      void'($urandom(5));
      repeat (10) @(posedge sys_clk);
      srst <= 1'b0;
      // Reset values, read-only counts and an unmapped word
      for (int a = 0; a < 8'h50; a += 4)
         if (a != 8'h44)
            rd(8'(a), a == 0 ? 32'h8 : a == 8'h24 ? 32'h20 :
               a == 8'h28 ? 32'h4 : 32'h0);
      rd(8'hFC, 32'h0);
      wr(8'h00, 32'hFFFF_FFFF);
      wr(8'h4C, 32'hFFFF_FFFF);
      rd(8'h00, 32'h8);
      rd(8'h4C, 32'h0);
      // Random levels, inversion and forcing, half with clock/direction
      for (int i = 0; i < 4; i++) begin
         r = $urandom();
         m = $urandom();
         fe = $urandom();
         fv = $urandom();
         lvl <= r;
         slow <= i[1];
         clk_dir_mode <= i[0];
         wr(dic_pkg::OFF_INVERT, m);
         wr(dic_pkg::OFF_FORCE_EN, fe);
         wr(dic_pkg::OFF_FORCE_VAL, fv);
         e = cond(r, m, fe, fv, i[0]);
         lv(1, e);
         rd(dic_pkg::OFF_RAW, r);
         rd(dic_pkg::OFF_RESULT, e);
      end
      // Special outputs follow result bits 0..3 only where enabled
      clk_dir_mode <= 1'b0;
      wr(dic_pkg::OFF_INVERT, 32'h0);
      wr(dic_pkg::OFF_FORCE_EN, 32'hF);
      for (int i = 0; i < 8; i++) begin
         fv = $urandom_range(15);
         fe = $urandom_range(15);
         wr(dic_pkg::OFF_FORCE_VAL, fv);
         wr(dic_pkg::OFF_SPECIAL_EN, 32'hFFFF_0000 | fe);
         lv(4, fv & fe);
      end
      e = $urandom();
      wr(dic_pkg::OFF_THRESH, e);
      lv(2, e);
      wr(dic_pkg::OFF_DIFF, 32'h1);
      lv(3, 32'h1);
      wr(dic_pkg::OFF_DIFF, 32'h0);
      lv(3, 32'h0);
      // Routing: selector k takes conditioned input k, selector 0 gives 0
      r = $urandom();
      lvl <= r;
      wr(dic_pkg::OFF_FORCE_EN, 32'h0);
      wr(dic_pkg::OFF_INVERT, m);
      c = cond(r, m, 32'h0, 32'h0, 1'b0);
      e = 32'h0;
      for (int i = 0; i < 32; i++) begin
         s = 8'($urandom_range(32));
         wr(dic_pkg::OFF_ROUTE_SEL + 8'(4 * i), {24'h0, s});
         if (s != 8'h00)
            e[i] = c[s - 8'h01];
      end
      wr(dic_pkg::OFF_ROUTE_EN, 32'h1);
      lv(1, e);
      rd(8'hFC, {24'h0, s});
      wr(dic_pkg::OFF_ROUTE_EN, 32'h0);
      lv(1, c);
      // Capture: home only, no homing run, all modes, masked then live irq
      lvl <= 32'h0;
      wr(dic_pkg::OFF_SPECIAL_EN, 32'h4);
      wr(dic_pkg::OFF_INVERT, 32'h0);
      idle(6);
      wr(dic_pkg::OFF_IRQ_CLEAR, 32'h7);
      last = '0;
      for (int k = 0; k < 4; k++) begin
         md = (k + 1) % 4;
         wr(dic_pkg::OFF_CAP_CTRL, 32'(md));
         p1 = {$urandom(), $urandom()};
         p2 = {$urandom(), $urandom()};
         pos_cmd <= p1;
         idle(3);
         lvl <= 32'h4;
         idle(8);
         pos_cmd <= p2;
         idle(3);
         lvl <= 32'h0;
         idle(8);
         if (md == 1)
            last = p1;
         else if (md != 0)
            last = p2;
         rd(dic_pkg::OFF_CAP_EVENTS, md == 1 || md == 2 ? 32'h1 : 32'h2);
         rd(dic_pkg::OFF_CAP_USER, last.user_pos);
         rd(dic_pkg::OFF_CAP_ENC, last.enc_pos);
      end
      rd(dic_pkg::OFF_IRQ_STATUS, 32'h1);
      lv(5, 32'h0);
      wr(dic_pkg::OFF_IRQ_ENABLE, 32'h1);
      lv(5, 32'h1);
      wr(dic_pkg::OFF_IRQ_CLEAR, 32'h1);
      lv(5, 32'h0);
      rd(dic_pkg::OFF_IRQ_STATUS, 32'h0);
      idle(4);
      end_of_test();
   end
endmodule
